// File: hw/analog_select_and_reset_input.sv
// Purpose: analog source selection and reset terminal handling
// Assumes: inputs synchronous to clk_i
// Notes: power-on reset of nrst_i is treated as a reset pulse
`timescale 1ns/100ps
`default_nettype none
module analog_select_and_reset_input #(
	parameter int RS_MIN_CYC    = ars_pkg::RS_MIN_CYC,
	parameter int ALARM_MAX_CYC = ars_pkg::ALARM_MAX_CYC,
	parameter int OFF_HOLD_CYC  = ars_pkg::OFF_HOLD_CYC,
	parameter int KEY_WIN_CYC   = ars_pkg::KEY_WIN_CYC,
	parameter int DEB_CYC       = ars_pkg::DEB_CYC
) (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          nrst_i,
	// Terminals and settings
	input  wire ars_pkg::term_type             term_i,
	input  wire logic [1:0]                    freq_src_i,
	input  wire logic [1:0]                    comb_i,
	input  wire logic                          remote_op_i,
	input  wire logic [ars_pkg::NUM_OUT-1:0]   out_req_i,
	input  wire logic [ars_pkg::NUM_OUT-1:0]   out_dly_en_i,
	// Status and controls
	output ars_pkg::src_type                   src_o,
	output logic                               drive_en_o,
	output logic                               coast_o,
	output logic                               alarm_o,
	output logic                               trip_o,
	output logic                               pwr_reset_o,
	output logic                               key_ok_o,
	output logic [ars_pkg::NUM_OUT-1:0]        out_o
);
	////////////////////////////////////////////////////////////////
	// Debounce
	logic [ars_pkg::CNT_W-1:0] dsel_cnt_r;
	logic [ars_pkg::CNT_W-1:0] drst_cnt_r;
	logic                      sel_r;
	logic                      rst_r;

	function automatic logic [ars_pkg::CNT_W-1:0] step(input logic [ars_pkg::CNT_W-1:0] c,
		input logic differ);
		if (!differ)
			step = '0;
		else
			step = c + 27'h1;
	endfunction

	wire logic rst_raw = term_i.rst & ~term_i.rst_nc;
	wire logic sel_flip = (dsel_cnt_r >= ars_pkg::CNT_W'(DEB_CYC - 1)) && (term_i.sel != sel_r);
	wire logic rst_flip = (drst_cnt_r >= ars_pkg::CNT_W'(DEB_CYC - 1)) && (rst_raw != rst_r);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dsel_cnt_r <= '0;
			drst_cnt_r <= '0;
			sel_r      <= 1'b0;
			rst_r      <= 1'b0;
		end else begin
			dsel_cnt_r <= sel_flip ? '0 : step(dsel_cnt_r, term_i.sel != sel_r);
			drst_cnt_r <= rst_flip ? '0 : step(drst_cnt_r, rst_raw != rst_r);
			sel_r      <= sel_flip ? term_i.sel : sel_r;
			rst_r      <= rst_flip ? rst_raw : rst_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// Analog source selection
	wire logic is_analog = (freq_src_i == ars_pkg::FSRC_ANALOG);
	wire ars_pkg::src_type on_src = (comb_i == ars_pkg::COMB_00) ? ars_pkg::SRC_VOLT :
		(comb_i == ars_pkg::COMB_03) ? ars_pkg::SRC_POT : ars_pkg::SRC_CURR;
	wire ars_pkg::src_type off_src = (comb_i == ars_pkg::COMB_00 || comb_i == ars_pkg::COMB_03) ?
		ars_pkg::SRC_CURR : ars_pkg::SRC_VOLT;
	wire ars_pkg::src_type src_nxt = !is_analog ? ars_pkg::SRC_OTHER : (sel_r ? on_src : off_src);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			src_o <= ars_pkg::SRC_OTHER;
		else
			src_o <= src_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Reset sequence
	ars_pkg::rst_state_type    st_r;
	logic [ars_pkg::CNT_W-1:0] on_cnt_r;
	logic [ars_pkg::CNT_W-1:0] hold_cnt_r;
	logic [ars_pkg::CNT_W-1:0] key_cnt_r;
	logic                      pwr_r;

	wire logic qualified = (on_cnt_r >= ars_pkg::CNT_W'(RS_MIN_CYC - DEB_CYC));
	wire logic do_reset = (st_r == ars_pkg::ST_ON) && !rst_r && qualified;
	wire logic reset_act = rst_r | pwr_r;
	wire logic hold_run = (hold_cnt_r != '0);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r     <= ars_pkg::ST_IDLE;
			on_cnt_r <= '0;
		end else begin
			case (st_r)
				ars_pkg::ST_IDLE: begin
					on_cnt_r <= '0;
					if (rst_r)
						st_r <= ars_pkg::ST_ON;
				end
				ars_pkg::ST_ON: begin
					if (!qualified)
						on_cnt_r <= on_cnt_r + 27'h1;
					if (!rst_r)
						st_r <= qualified ? ars_pkg::ST_RESET : ars_pkg::ST_IDLE;
				end
				ars_pkg::ST_RESET: st_r <= ars_pkg::ST_IDLE;
				default: st_r <= ars_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwr_r     <= 1'b1;
			trip_o    <= 1'b0;
			alarm_o   <= 1'b0;
			key_cnt_r <= '0;
		end else begin
			pwr_r     <= 1'b0;
			trip_o    <= (term_i.trip && !reset_act) ? 1'b1 : (reset_act ? 1'b0 : trip_o);
			alarm_o   <= (term_i.trip && !reset_act) ? 1'b1 : (rst_r ? 1'b0 : alarm_o);
			key_cnt_r <= (key_cnt_r < ars_pkg::CNT_W'(KEY_WIN_CYC)) ? key_cnt_r + 27'h1 : key_cnt_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// Motor drive and logic outputs
	logic                        was_on_r;
	logic [ars_pkg::NUM_OUT-1:0] out_last_r;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drive_en_o <= 1'b0;
			coast_o    <= 1'b0;
			key_ok_o   <= 1'b0;
			hold_cnt_r <= '0;
			was_on_r   <= 1'b0;
			out_last_r <= '0;
			out_o      <= '0;
		end else begin
			drive_en_o <= term_i.run && !reset_act && !trip_o;
			coast_o    <= reset_act && (drive_en_o || coast_o) && term_i.run;
			key_ok_o   <= !remote_op_i || (key_cnt_r < ars_pkg::CNT_W'(KEY_WIN_CYC));
			was_on_r   <= rst_r;
			if (rst_r && !was_on_r)
				hold_cnt_r <= ars_pkg::CNT_W'(OFF_HOLD_CYC);
			else if (hold_run)
				hold_cnt_r <= hold_cnt_r - 27'h1;
			if (!reset_act)
				out_last_r <= out_req_i;
			if (!reset_act)
				out_o <= out_req_i;
			else
				out_o <= (hold_run && !(rst_r && !was_on_r)) || (rst_r && !was_on_r) ?
					(out_last_r & out_dly_en_i) : '0;
		end
	end

	assign pwr_reset_o = reset_act | (st_r == ars_pkg::ST_RESET);

	////////////////////////////////////////////////////////////////
	// Assertions
	logic [ars_pkg::CNT_W-1:0] alm_wait_r;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			alm_wait_r <= '0;
		else if (rst_raw && alarm_o)
			alm_wait_r <= step(alm_wait_r, 1'b1);
		else
			alm_wait_r <= '0;
	end

	property p_alarm_lim;
		@(posedge clk_i) disable iff (!nrst_i)
		alm_wait_r < ars_pkg::CNT_W'(ALARM_MAX_CYC);
	endproperty
	a_alarm_lim: assert property (p_alarm_lim) else $error("alarm held past limit");

	property p_src_cur;
		@(posedge clk_i) disable iff (!nrst_i)
		(is_analog && sel_r && comb_i == 2'h1) |=> (src_o == ars_pkg::SRC_CURR);
	endproperty
	a_src_cur: assert property (p_src_cur) else $error("select on not current");

	property p_src_volt;
		@(posedge clk_i) disable iff (!nrst_i)
		(is_analog && !sel_r && comb_i == 2'h1) |=> (src_o == ars_pkg::SRC_VOLT);
	endproperty
	a_src_volt: assert property (p_src_volt) else $error("select off not voltage");

	property p_src_other;
		@(posedge clk_i) disable iff (!nrst_i)
		!is_analog |=> (src_o == ars_pkg::SRC_OTHER);
	endproperty
	a_src_other: assert property (p_src_other) else $error("select active off analog");

	property p_comb;
		@(posedge clk_i) disable iff (!nrst_i)
		(is_analog && sel_r && comb_i == ars_pkg::COMB_03) |=> (src_o == ars_pkg::SRC_POT);
	endproperty
	a_comb: assert property (p_comb) else $error("combination 03 wrong");

	property p_trip_clr;
		@(posedge clk_i) disable iff (!nrst_i)
		(rst_r && !term_i.trip) |=> !trip_o;
	endproperty
	a_trip_clr: assert property (p_trip_clr) else $error("trip not cleared");

	property p_alarm;
		@(posedge clk_i) disable iff (!nrst_i)
		($rose(rst_r) && !term_i.trip) |-> ##[1:2] !alarm_o;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not cleared");

	property p_nodrive;
		@(posedge clk_i) disable iff (!nrst_i)
		rst_r |=> !drive_en_o;
	endproperty
	a_nodrive: assert property (p_nodrive) else $error("drive during reset");

	property p_nodly_off;
		@(posedge clk_i) disable iff (!nrst_i)
		(rst_r && out_dly_en_i == '0) |=> (out_o == '0);
	endproperty
	a_nodly_off: assert property (p_nodly_off) else $error("output not off");

	property p_nc;
		@(posedge clk_i) disable iff (!nrst_i)
		term_i.rst_nc |=> ##1 (st_r != ars_pkg::ST_RESET);
	endproperty
	a_nc: assert property (p_nc) else $error("reset from nc terminal");

	c_reset: cover property (@(posedge clk_i) disable iff (!nrst_i) st_r == ars_pkg::ST_RESET);
	c_pot: cover property (@(posedge clk_i) disable iff (!nrst_i) src_o == ars_pkg::SRC_POT);
	c_coast: cover property (@(posedge clk_i) disable iff (!nrst_i) coast_o);
	c_hold: cover property (@(posedge clk_i) disable iff (!nrst_i) hold_run && out_o != '0);
endmodule
`default_nettype wire

// File: shared/ars_pkg.sv
// Purpose: constants and types for analog select and reset input logic
// Assumes: 25 MHz clock, terminal inputs synchronous to clk_i
// Notes: times are named in their own units, counts derived from them
//
// What this block does
// - Select on picks current input
// - Select off picks voltage input
// - Select acts only with analog source
// - Combination 00 and 03 remap the select
// - Reset runs on terminal on then off
// - Alarm cleared within 30 ms of onset
// - Reset returns trip to normal
// - Reset on: drive off, trip cleared, powerup reset
// - Reset while running makes motor coast
// - Reset terminal only normally open
// - Power-on performs the same reset
// - No delay: outputs off together at once
// - Delayed outputs stay on about 1 s
// - Local stop key only briefly after powerup in remote operation
// - Run resumes after reset if still commanded
package ars_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int RS_MIN_MS = 12;
	localparam int ALARM_MAX_MS = 30;
	localparam int OFF_HOLD_MS = 1000;
	localparam int KEY_WIN_MS = 3000;
	localparam int DEB_US = 1000;
	localparam int RS_MIN_CYC = (CLK_HZ / 1000) * RS_MIN_MS;
	localparam int ALARM_MAX_CYC = (CLK_HZ / 1000) * ALARM_MAX_MS;
	localparam int OFF_HOLD_CYC = (CLK_HZ / 1000) * OFF_HOLD_MS;
	localparam int KEY_WIN_CYC = (CLK_HZ / 1000) * KEY_WIN_MS;
	localparam int DEB_CYC = (CLK_HZ / 1000000) * DEB_US;
	localparam int CNT_W = 27;
	localparam int NUM_OUT = 3;
	localparam logic [1:0] FSRC_ANALOG = 2'h1;
	localparam logic [1:0] COMB_00 = 2'h0;
	localparam logic [1:0] COMB_03 = 2'h3;
	typedef enum logic [1:0] {SRC_VOLT, SRC_CURR, SRC_POT, SRC_OTHER} src_type;
	typedef struct packed {
		logic       sel;
		logic       rst;
		logic       rst_nc;
		logic       run;
		logic       trip;
		logic       key;
	} term_type;
	typedef enum {ST_IDLE, ST_ON, ST_RESET} rst_state_type;
endpackage

// File: testbench/reset_switch.sv
// Purpose: reset contact model
// Assumes: one request at a time
// Notes: short mode breaks min width
`timescale 1ns/100ps
`default_nettype none
module reset_switch #(
	parameter int LONG_CYC  = 60,
	parameter int SHORT_CYC = 10
) (
	// Control
	input  wire logic clk_i,
	input  wire logic req_i,
	input  wire logic short_i,
	// Contact
	output logic      rst_o
);
	logic [7:0] cnt_r = 8'h00;
	assign rst_o = (cnt_r != 8'h00);
	always_ff @(posedge clk_i) begin
		if (req_i && cnt_r == 8'h00) begin
			cnt_r <= short_i ? 8'(SHORT_CYC) : 8'(LONG_CYC);
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: testbench/test_analog_select_and_reset_input.sv
// Purpose: bench for select and reset
// Assumes: shortened counts
// Notes: checks queued, compared at negedge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module test_analog_select_and_reset_input;
	localparam int W = 7;
	logic clk_i = 0, nrst_i = 0, sel = 0, rst_nc = 0, run = 0, trip = 0, key = 0;
	logic remote = 1, req = 0, shrt = 0, rst_w;
	logic [1:0] fsrc = 2'h1, comb = 2'h0;
	logic [2:0] oreq = 3'h0, dly = 3'h0, out_o;
	ars_pkg::src_type src_o;
	logic drv, cst, alm, trp, pwr, kok;
	logic [21:0] exp_q[$];
	logic [21:0] ent;
	logic [10:0] obs;
	int num_errors = 0, check_count = 0, cyc = 0;
	assign obs = {src_o, drv, cst, alm, trp, pwr, kok, out_o};
	analog_select_and_reset_input #(.RS_MIN_CYC(40), .ALARM_MAX_CYC(750), .OFF_HOLD_CYC(20),
		.KEY_WIN_CYC(50), .DEB_CYC(4)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.term_i({sel, rst_w, rst_nc, run, trip, key}), .freq_src_i(fsrc), .comb_i(comb),
		.remote_op_i(remote), .out_req_i(oreq), .out_dly_en_i(dly), .src_o(src_o),
		.drive_en_o(drv), .coast_o(cst), .alarm_o(alm), .trip_o(trp), .pwr_reset_o(pwr),
		.key_ok_o(kok), .out_o(out_o));
	reset_switch sw (.clk_i(clk_i), .req_i(req), .short_i(shrt), .rst_o(rst_w));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			print_verdict();
		end
	end
	always @(negedge clk_i) begin
		if (exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			`CHK(obs & ent[21:11], ent[10:0])
		end
	end
	task automatic note(input logic [10:0] m, input logic [10:0] e);
		exp_q.push_back({m, e & m});
		@(posedge clk_i);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic pulse(input logic s);
		shrt <= s;
		req <= 1'b1;
		@(posedge clk_i);
		req <= 1'b0;
	endtask
	initial begin
		logic [1:0] c;
		logic [1:0] e;
		int r;
		void'($urandom(11955));
		tick(8);
		nrst_i <= 1'b1;
		tick(4);
		note(11'h008, 11'h008);
		for (int i = 0; i < 12; i++) begin
			c = (i % 6 < 2) ? 2'h0 : ((i % 6 < 4) ? 2'h3 : 2'h1);
			r = $urandom % 3;
			sel <= i[0];
			comb <= c;
			fsrc <= (i < 6) ? 2'h1 : ((r == 1) ? 2'h3 : 2'(r));
			e = (i >= 6) ? 2'h3 : (c == 2'h0) ? (i[0] ? 2'h0 : 2'h1) :
				(c == 2'h3) ? (i[0] ? 2'h2 : 2'h1) : (i[0] ? 2'h1 : 2'h0);
			tick(W);
			note(11'h600, {e, 9'h0});
		end
		note(11'h008, 11'h000);
		remote <= 1'b0;
		tick(2);
		note(11'h008, 11'h008);
		$display("select test done");
		oreq <= 3'($urandom);
		dly <= 3'($urandom) | 3'h1;
		run <= 1'b1;
		tick(W);
		note(11'h107, {3'h1, 5'h0, oreq});
		pulse(1'b0);
		tick(W);
		note(11'h197, {3'h0, 1'b1, 2'h0, 1'b1, 1'b0, oreq & dly});
		tick(20);
		note(11'h007, 11'h000);
		tick(45);
		note(11'h100, 11'h100);
		$display("run reset test done");
		trip <= 1'b1;
		tick(W);
		trip <= 1'b0;
		note(11'h060, 11'h060);
		pulse(1'b0);
		tick(W);
		note(11'h060, 11'h000);
		tick(60);
		rst_nc <= 1'b1;
		trip <= 1'b1;
		tick(W);
		trip <= 1'b0;
		pulse(1'b0);
		tick(W);
		note(11'h020, 11'h020);
		tick(60);
		rst_nc <= 1'b0;
		$display("trip test done");
		pulse(1'b1);
		tick(W);
		note(11'h030, 11'h010);
		tick(W);
		for (int i = 0; i < 10; i++) note(11'h010, 11'h000);
		$display("short pulse test done");
		nrst_i <= 1'b0;
		tick(2);
		nrst_i <= 1'b1;
		note(11'h130, 11'h010);
		tick(W);
		note(11'h110, 11'h100);
		$display("power reset test done");
		print_verdict();
	end
endmodule
`default_nettype wire
